/* File: shared/iss_pkg.sv */
// Constants for the internal input source select block.
// Assumes a 32-bit APB slave; each register is one aligned word at four times its index.
package iss_pkg;

	// ********************************************************
	// Register map
	// ********************************************************
	// Register indices; the byte address is four times the index.
	localparam logic [7:0]  IDX_MOD_SEL   = 8'h18;
	localparam logic [7:0]  IDX_DAC_SEL   = 8'h19;
	localparam logic [7:0]  IDX_TMR_SEL   = 8'h1a;
	localparam int          REG_W         = 16;
	localparam int          DATA_W        = 32;
	localparam logic [15:0] RST_MOD_SEL   = 16'h0000;
	localparam logic [15:0] RST_DAC_SEL   = 16'h0000;
	localparam logic [15:0] RST_TMR_SEL   = 16'h0000;
	// Bits that hold a field; every other bit is reserved and reads as zero.
	localparam logic [15:0] WMASK_MOD_SEL = 16'h003f;
	localparam logic [15:0] WMASK_DAC_SEL = 16'h0077;
	localparam logic [15:0] WMASK_TMR_SEL = 16'h1110;

	// ********************************************************
	// Field positions
	// ********************************************************
	localparam int SEL_W       = 3;
	localparam int PAIR23_LSB  = 3;
	localparam int PAIR01_LSB  = 0;
	localparam int DAC1_LSB    = 4;
	localparam int DAC0_LSB    = 0;
	localparam int TA3_BIT     = 12;
	localparam int TA2_BIT     = 8;
	localparam int TA1_BIT     = 4;

	// ********************************************************
	// Select codes
	// ********************************************************
	localparam logic [2:0] PAIR_PIN      = 3'h0;
	localparam logic [2:0] PAIR_TIMER    = 3'h1;
	localparam logic [2:0] PAIR_ADC      = 3'h2;
	localparam logic [2:0] PAIR_CMPA     = 3'h3;
	localparam logic [2:0] PAIR_CMPB     = 3'h4;
	localparam logic [2:0] DSYNC_PIT     = 3'h0;
	localparam logic [2:0] DSYNC_RELOAD  = 3'h3;
	localparam logic [2:0] DSYNC_TA0     = 3'h4;
	localparam logic [2:0] DSYNC_TA1     = 3'h5;

endpackage

/* File: shared/iss_pair_if.sv */
// Carries one modulator pair-source selection between the register block and the pair selector.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface iss_pair_if #(
	parameter int ADC_W = 12
);
	logic [2:0]       sel;
	logic             pinIn;
	logic             timerIn;
	logic             cmpA;
	logic             cmpB;
	logic             adcValid;
	logic [ADC_W-1:0] adcResult;
	logic [ADC_W-1:0] highLimit;
	logic [ADC_W-1:0] lowLimit;
	logic             pairSource;
	logic             limitMode;
	logic             evenLevel;
	logic             oddLevel;

	modport ctrl (
		output sel, pinIn, timerIn, cmpA, cmpB, adcValid, adcResult, highLimit, lowLimit,
		input  pairSource, limitMode, evenLevel, oddLevel
	);
	modport pair (
		input  sel, pinIn, timerIn, cmpA, cmpB, adcValid, adcResult, highLimit, lowLimit,
		output pairSource, limitMode, evenLevel, oddLevel
	);
endinterface // iss_pair_if

/* File: hdl/iss_pair_source.sv */
// Source selector for one modulator output pair, with the ADC limit option.
// Assumes pin inputs are already synchronised and the ADC strobe is on the system clock.
`timescale 1ns/1ps
module iss_pair_source
	import iss_pkg::*;
(
	input  wire logic sys_clk,
	input  wire logic rstn,
	iss_pair_if.pair  pairBus
);

	typedef struct packed {
		logic evenLevel;
		logic oddLevel;
	} iss_pair_state_t;

	iss_pair_state_t state_q;
	iss_pair_state_t state_d;

	// ********************************************************
	// Limit tracking
	// ********************************************************
	// Between the two limits the pair keeps its last levels.
	always_comb begin
		state_d = state_q;
		if (pairBus.sel == PAIR_ADC && pairBus.adcValid) begin
			if (pairBus.adcResult > pairBus.highLimit) begin
				state_d.evenLevel = 1'b0;
				state_d.oddLevel  = 1'b1;
			end else if (pairBus.adcResult < pairBus.lowLimit) begin
				state_d.evenLevel = 1'b1;
				state_d.oddLevel  = 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	// ********************************************************
	// Source multiplexer
	// ********************************************************
	always_comb begin
		case (pairBus.sel)
			PAIR_PIN:   pairBus.pairSource = pairBus.pinIn;
			PAIR_TIMER: pairBus.pairSource = pairBus.timerIn;
			PAIR_ADC:   pairBus.pairSource = state_q.evenLevel;
			PAIR_CMPA:  pairBus.pairSource = pairBus.cmpA;
			PAIR_CMPB:  pairBus.pairSource = pairBus.cmpB;
			default:    pairBus.pairSource = 1'b0;
		endcase
	end

	assign pairBus.limitMode = (pairBus.sel == PAIR_ADC);
	assign pairBus.evenLevel = state_q.evenLevel;
	assign pairBus.oddLevel  = state_q.oddLevel;

endmodule // iss_pair_source

/* File: hdl/iss_source_select.sv */
// Internal input source select registers and multiplexers.
// Assumes an APB master on sys_clk; pins are asynchronous, all other inputs are on sys_clk.
//
// Contract
// - Pair 2/3 field bits 5..3: pin, timer ch2, ADC sample one, comparator A, comparator B.
// - ADC sample one above high limit drives output two low, output three high.
// - ADC sample one below low limit drives output two high, output three low.
// - Pair 0/1 field bits 2..0: pin, timer ch0, ADC sample zero, comparator A, B.
// - ADC sample zero above high limit drives output zero low, output one high.
// - ADC sample zero below low limit drives output zero high, output one low.
// - DAC one sync field bits 6..4: interval timer, reload sync, timer ch0, ch1.
// - DAC zero sync field bits 2..0 uses the same encoding as DAC one.
// - Bit 12 feeds timer input three from its pin or the reload sync.
// - Bit 8 feeds timer input two from its pin or comparator B.
// - Bit 4 feeds timer input one from its pin or comparator A.
//
// Local design decision: register access over APB.
`timescale 1ns/1ps
module iss_source_select
	import iss_pkg::*;
#(
	parameter int ADDR_W = 12,
	parameter int ADC_W  = 12
) (
	input  wire logic              sys_clk,
	input  wire logic              rstn,
	// APB slave.
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	input  wire logic [3:0]        pstrb,
	output      logic              pready,
	output      logic [31:0]       prdata,
	output      logic              pslverr,
	// Pins, asynchronous to sys_clk.
	input  wire logic              pair01SourceIn,
	input  wire logic              pair23SourceIn,
	input  wire logic              timerAIn1Pin,
	input  wire logic              timerAIn2Pin,
	input  wire logic              timerAIn3Pin,
	// Internal sources on sys_clk.
	input  wire logic              timerAChanZero,
	input  wire logic              timerAChanOne,
	input  wire logic              timerAChanTwo,
	input  wire logic              comparatorAOut,
	input  wire logic              comparatorBOut,
	input  wire logic              intervalTimerZeroOut,
	input  wire logic              reloadSync,
	input  wire logic              adcValidZero,
	input  wire logic [ADC_W-1:0]  adcResultZero,
	input  wire logic [ADC_W-1:0]  sampleZeroHighLimit,
	input  wire logic [ADC_W-1:0]  sampleZeroLowLimit,
	input  wire logic              adcValidOne,
	input  wire logic [ADC_W-1:0]  adcResultOne,
	input  wire logic [ADC_W-1:0]  sampleOneHighLimit,
	input  wire logic [ADC_W-1:0]  sampleOneLowLimit,
	// Modulator pair sources.
	output      logic              pair01Source,
	output      logic              pair01LimitMode,
	output      logic              pwm0Level,
	output      logic              pwm1Level,
	output      logic              pair23Source,
	output      logic              pair23LimitMode,
	output      logic              pwm2Level,
	output      logic              pwm3Level,
	// DAC sync inputs.
	output      logic              dac0Sync,
	output      logic              dac1Sync,
	// Timer inputs.
	output      logic              timerAIn1,
	output      logic              timerAIn2,
	output      logic              timerAIn3
);

	// ********************************************************
	// State
	// ********************************************************
	localparam int PIN_N = 5;
	localparam int PIN_P01 = 0;
	localparam int PIN_P23 = 1;
	localparam int PIN_TA1 = 2;
	localparam int PIN_TA2 = 3;
	localparam int PIN_TA3 = 4;

	typedef struct packed {
		logic [REG_W-1:0] modSel;
		logic [REG_W-1:0] dacSel;
		logic [REG_W-1:0] tmrSel;
		logic [31:0]      rdata;
		logic             rerr;
		logic [PIN_N-1:0] pinMeta;
		logic [PIN_N-1:0] pinSync;
	} iss_top_state_t;

	iss_top_state_t state_q;
	iss_top_state_t state_d;

	// ********************************************************
	// Helper functions
	// ********************************************************
	// True when the byte address is the aligned word of the given register index.
	function automatic logic hitReg(
		input logic [ADDR_W-1:0] addr,
		input logic [7:0]        idx
	);
		logic [ADDR_W-1:0] wordIdx;
		wordIdx = addr >> 2;
		return (addr[1:0] == 2'h0) && (wordIdx == ADDR_W'(idx));
	endfunction

	// Merges the enabled byte lanes of a write and drops reserved bits.
	function automatic logic [REG_W-1:0] laneMerge(
		input logic [REG_W-1:0] old,
		input logic [31:0]      wdata,
		input logic [3:0]       strb,
		input logic [REG_W-1:0] wmask
	);
		logic [REG_W-1:0] lanes;
		lanes = {{8{strb[1]}}, {8{strb[0]}}};
		return ((old & ~lanes) | (wdata[REG_W-1:0] & lanes)) & wmask;
	endfunction

	// Decodes a DAC sync select code; reserved codes give a quiet low.
	function automatic logic dacSyncMux(
		input logic [2:0] code,
		input logic       pit,
		input logic       reload,
		input logic       ta0,
		input logic       ta1
	);
		logic res;
		case (code)
			DSYNC_PIT:    res = pit;
			DSYNC_RELOAD: res = reload;
			DSYNC_TA0:    res = ta0;
			DSYNC_TA1:    res = ta1;
			default:      res = 1'b0;
		endcase
		return res;
	endfunction

	// ********************************************************
	// Bus decode
	// ********************************************************
	logic hitMod;
	logic hitDac;
	logic hitTmr;
	logic hitAny;
	logic setupPhase;
	logic writeNow;

	assign hitMod     = hitReg(paddr, IDX_MOD_SEL);
	assign hitDac     = hitReg(paddr, IDX_DAC_SEL);
	assign hitTmr     = hitReg(paddr, IDX_TMR_SEL);
	assign hitAny     = hitMod | hitDac | hitTmr;
	assign setupPhase = psel & ~penable;
	assign writeNow   = psel & penable & pwrite;

	// ********************************************************
	// Next state
	// ********************************************************
	// Read data and the error answer are captured in the setup cycle, so the
	// access phase always completes at once with stable data.
	always_comb begin
		state_d = state_q;
		state_d.pinMeta[PIN_P01] = pair01SourceIn;
		state_d.pinMeta[PIN_P23] = pair23SourceIn;
		state_d.pinMeta[PIN_TA1] = timerAIn1Pin;
		state_d.pinMeta[PIN_TA2] = timerAIn2Pin;
		state_d.pinMeta[PIN_TA3] = timerAIn3Pin;
		state_d.pinSync = state_q.pinMeta;
		if (setupPhase) begin
			state_d.rerr  = ~hitAny;
			state_d.rdata = '0;
			if (!pwrite) begin
				if (hitMod) begin
					state_d.rdata[REG_W-1:0] = state_q.modSel;
				end else if (hitDac) begin
					state_d.rdata[REG_W-1:0] = state_q.dacSel;
				end else if (hitTmr) begin
					state_d.rdata[REG_W-1:0] = state_q.tmrSel;
				end
			end
		end
		if (writeNow) begin
			if (hitMod) begin
				state_d.modSel = laneMerge(state_q.modSel, pwdata, pstrb, WMASK_MOD_SEL);
			end
			if (hitDac) begin
				state_d.dacSel = laneMerge(state_q.dacSel, pwdata, pstrb, WMASK_DAC_SEL);
			end
			if (hitTmr) begin
				state_d.tmrSel = laneMerge(state_q.tmrSel, pwdata, pstrb, WMASK_TMR_SEL);
			end
		end
	end

	// ********************************************************
	// Registers
	// ********************************************************
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			state_q        <= '0;
			state_q.modSel <= RST_MOD_SEL;
			state_q.dacSel <= RST_DAC_SEL;
			state_q.tmrSel <= RST_TMR_SEL;
		end else begin
			state_q <= state_d;
		end
	end

	assign pready  = 1'b1;
	assign prdata  = state_q.rdata;
	assign pslverr = psel & penable & state_q.rerr;

	// ********************************************************
	// Modulator pair sources
	// ********************************************************
	iss_pair_if #(.ADC_W(ADC_W)) pair01Bus ();
	iss_pair_if #(.ADC_W(ADC_W)) pair23Bus ();

	assign pair01Bus.sel       = state_q.modSel[PAIR01_LSB +: SEL_W];
	assign pair01Bus.pinIn     = state_q.pinSync[PIN_P01];
	assign pair01Bus.timerIn   = timerAChanZero;
	assign pair01Bus.cmpA      = comparatorAOut;
	assign pair01Bus.cmpB      = comparatorBOut;
	assign pair01Bus.adcValid  = adcValidZero;
	assign pair01Bus.adcResult = adcResultZero;
	assign pair01Bus.highLimit = sampleZeroHighLimit;
	assign pair01Bus.lowLimit  = sampleZeroLowLimit;

	assign pair23Bus.sel       = state_q.modSel[PAIR23_LSB +: SEL_W];
	assign pair23Bus.pinIn     = state_q.pinSync[PIN_P23];
	assign pair23Bus.timerIn   = timerAChanTwo;
	assign pair23Bus.cmpA      = comparatorAOut;
	assign pair23Bus.cmpB      = comparatorBOut;
	assign pair23Bus.adcValid  = adcValidOne;
	assign pair23Bus.adcResult = adcResultOne;
	assign pair23Bus.highLimit = sampleOneHighLimit;
	assign pair23Bus.lowLimit  = sampleOneLowLimit;

	iss_pair_source u_pair01 (
		.sys_clk (sys_clk),
		.rstn    (rstn),
		.pairBus (pair01Bus.pair)
	);

	iss_pair_source u_pair23 (
		.sys_clk (sys_clk),
		.rstn    (rstn),
		.pairBus (pair23Bus.pair)
	);

	assign pair01Source    = pair01Bus.pairSource;
	assign pair01LimitMode = pair01Bus.limitMode;
	assign pwm0Level       = pair01Bus.evenLevel;
	assign pwm1Level       = pair01Bus.oddLevel;
	assign pair23Source    = pair23Bus.pairSource;
	assign pair23LimitMode = pair23Bus.limitMode;
	assign pwm2Level       = pair23Bus.evenLevel;
	assign pwm3Level       = pair23Bus.oddLevel;

	// ********************************************************
	// DAC sync selection
	// ********************************************************
	assign dac1Sync = dacSyncMux(state_q.dacSel[DAC1_LSB +: SEL_W], intervalTimerZeroOut,
		reloadSync, timerAChanZero, timerAChanOne);
	assign dac0Sync = dacSyncMux(state_q.dacSel[DAC0_LSB +: SEL_W], intervalTimerZeroOut,
		reloadSync, timerAChanZero, timerAChanOne);

	// ********************************************************
	// Timer input selection
	// ********************************************************
	// The reload sync is only meaningful when both ends share a clock rate.
	assign timerAIn3 = state_q.tmrSel[TA3_BIT] ? reloadSync : state_q.pinSync[PIN_TA3];
	assign timerAIn2 = state_q.tmrSel[TA2_BIT] ? comparatorBOut : state_q.pinSync[PIN_TA2];
	assign timerAIn1 = state_q.tmrSel[TA1_BIT] ? comparatorAOut : state_q.pinSync[PIN_TA1];

endmodule // iss_source_select

/* File: sim/iss_source_select_sva.sv */
// Checker for the source select block, watching only the top module's ports.
// Assumes one sys_clk domain with rstn as asynchronous active-low reset.
`timescale 1ns/1ps
module iss_source_select_sva
	import iss_pkg::*;
#(
	parameter int ADDR_W = 12,
	parameter int ADC_W  = 12
) (
	input wire logic              sys_clk,
	input wire logic              rstn,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic              pready,
	input wire logic [31:0]       prdata,
	input wire logic              pslverr,
	input wire logic              adcValidZero,
	input wire logic [ADC_W-1:0]  adcResultZero,
	input wire logic [ADC_W-1:0]  sampleZeroHighLimit,
	input wire logic [ADC_W-1:0]  sampleZeroLowLimit,
	input wire logic              adcValidOne,
	input wire logic [ADC_W-1:0]  adcResultOne,
	input wire logic [ADC_W-1:0]  sampleOneHighLimit,
	input wire logic [ADC_W-1:0]  sampleOneLowLimit,
	input wire logic              pair01Source,
	input wire logic              pair01LimitMode,
	input wire logic              pwm0Level,
	input wire logic              pwm1Level,
	input wire logic              pair23Source,
	input wire logic              pair23LimitMode,
	input wire logic              pwm2Level,
	input wire logic              pwm3Level
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);

	sequence s_hi0; adcValidZero && pair01LimitMode && (adcResultZero > sampleZeroHighLimit); endsequence
	sequence s_lo0; adcValidZero && pair01LimitMode && (adcResultZero < sampleZeroLowLimit); endsequence
	sequence s_in0;
		adcValidZero && pair01LimitMode && (adcResultZero <= sampleZeroHighLimit) && (adcResultZero >= sampleZeroLowLimit);
	endsequence
	sequence s_hi1; adcValidOne && pair23LimitMode && (adcResultOne > sampleOneHighLimit); endsequence
	sequence s_lo1; adcValidOne && pair23LimitMode && (adcResultOne < sampleOneLowLimit); endsequence

	chk_above_zero: assert property (s_hi0 |=> !pwm0Level && pwm1Level)
		else $error("pair01 above-limit levels wrong");
	chk_below_zero: assert property (s_lo0 |=> pwm0Level && !pwm1Level)
		else $error("pair01 below-limit levels wrong");
	chk_inside_hold: assert property (s_in0 |=> $stable({pwm0Level, pwm1Level}))
		else $error("pair01 levels moved inside limits");
	chk_above_one: assert property (s_hi1 |=> !pwm2Level && pwm3Level)
		else $error("pair23 above-limit levels wrong");
	chk_below_one: assert property (s_lo1 |=> pwm2Level && !pwm3Level)
		else $error("pair23 below-limit levels wrong");
	chk_idle_hold: assert property (!pair23LimitMode |=> $stable({pwm2Level, pwm3Level}))
		else $error("pair23 levels moved outside limit mode");
	chk_adc_src0: assert property (pair01LimitMode |-> pair01Source == pwm0Level)
		else $error("pair01 source not the limit level");
	chk_adc_src1: assert property (pair23LimitMode |-> pair23Source == pwm2Level)
		else $error("pair23 source not the limit level");
	chk_err_map: assert property (psel && penable |-> pready && (pslverr == !(paddr inside {12'h060, 12'h064, 12'h068})))
		else $error("error response does not match address map");
	chk_dac_resv: assert property (psel && penable && !pwrite && paddr == 12'h064 |-> (prdata & ~32'h0000_0077) == 32'h0000_0000)
		else $error("reserved DAC select bits read nonzero");
	chk_tmr_resv: assert property (psel && penable && !pwrite && paddr == 12'h068 |-> (prdata & ~32'h0000_1110) == 32'h0000_0000)
		else $error("reserved timer select bits read nonzero");
endmodule // iss_source_select_sva

/* File: sim/iss_src_partner.sv */
// Far-side source model: timer, comparator, interval timer and reload levels, plus ADC samples.
// Assumes sample requests from the bench arrive on sys_clk edges.
`timescale 1ns/1ps
module iss_src_partner (
	input  wire logic        sys_clk,
	input  wire logic        rstn,
	input  wire logic        req0,
	input  wire logic        req1,
	input  wire logic [11:0] reqVal,
	output      logic [6:0]  src,
	output      logic        valid0,
	output      logic        valid1,
	output      logic [11:0] res0,
	output      logic [11:0] res1
);
	// Results between samples invert every cycle so stale data is never mistaken for valid.
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			src    <= 7'h00;
			valid0 <= 1'b0;
			valid1 <= 1'b0;
			res0   <= 12'h000;
			res1   <= 12'h000;
		end else begin
			src    <= src + 7'h01;
			valid0 <= req0;
			valid1 <= req1;
			res0   <= req0 ? reqVal : ~res0;
			res1   <= req1 ? reqVal : ~res1;
		end
	end
endmodule // iss_src_partner

/* File: sim/tb_top.sv */
// Testbench for the source select block: APB register access and checks of every multiplexer.
// Assumes the checker and the partner model are compiled before this file.
`timescale 1ns/1ps
module tb_top
	import iss_pkg::*;
;
	localparam logic [11:0] A_MOD = {2'b00, IDX_MOD_SEL, 2'b00};
	localparam logic [11:0] A_DAC = {2'b00, IDX_DAC_SEL, 2'b00};
	localparam logic [11:0] A_TMR = {2'b00, IDX_TMR_SEL, 2'b00};
	logic        sys_clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000, reqVal = 12'h000, hiLim = 12'h800, loLim = 12'h400;
	logic [31:0] pwdata = 32'h0000_0000, prdata;
	logic [4:0]  pins = 5'h15;
	logic [3:0]  pstrb = 4'hf;
	logic        req0 = 1'b0, req1 = 1'b0, pready, pslverr, v0, v1;
	logic [6:0]  src;
	logic [11:0] r0, r1;
	logic        p01s, p01m, w0, w1, p23s, p23m, w2, w3, d0, d1, t1, t2, t3;
	int          n_mismatch = 0, checked = 0;

	initial begin
		forever #25 sys_clk = ~sys_clk;
	end

	iss_src_partner PART (.sys_clk(sys_clk), .rstn(rstn), .req0(req0), .req1(req1), .reqVal(reqVal), .src(src),
		.valid0(v0), .valid1(v1), .res0(r0), .res1(r1));

	iss_source_select DUT (.sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.pair01SourceIn(pins[0]), .pair23SourceIn(pins[1]), .timerAIn1Pin(pins[2]), .timerAIn2Pin(pins[3]),
		.timerAIn3Pin(pins[4]), .timerAChanZero(src[0]), .timerAChanOne(src[1]), .timerAChanTwo(src[2]),
		.comparatorAOut(src[3]), .comparatorBOut(src[4]), .intervalTimerZeroOut(src[5]), .reloadSync(src[6]),
		.adcValidZero(v0), .adcResultZero(r0), .sampleZeroHighLimit(hiLim), .sampleZeroLowLimit(loLim),
		.adcValidOne(v1), .adcResultOne(r1), .sampleOneHighLimit(hiLim), .sampleOneLowLimit(loLim),
		.pair01Source(p01s), .pair01LimitMode(p01m), .pwm0Level(w0), .pwm1Level(w1), .pair23Source(p23s),
		.pair23LimitMode(p23m), .pwm2Level(w2), .pwm3Level(w3), .dac0Sync(d0), .dac1Sync(d1),
		.timerAIn1(t1), .timerAIn2(t2), .timerAIn3(t3));

	// ********************************************************
	// Access and compare tasks
	// ********************************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
		int k;
		k = 0;
		@(posedge sys_clk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do @(posedge sys_clk); while (pready !== 1'b1 && ++k < 20);
		if (k >= 20) n_mismatch++;
		r = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wrc(input logic [11:0] a, input logic [31:0] d, input logic [31:0] x);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
		chk(e, 0);
		apb(1'b0, a, 0, r, e);
		chk(r, x);
		#1;
	endtask

	task automatic adc(input logic w, input logic [11:0] v);
		@(posedge sys_clk);
		req0   <= !w;
		req1   <= w;
		reqVal <= v;
		@(posedge sys_clk);
		req0   <= 1'b0;
		req1   <= 1'b0;
		@(posedge sys_clk);
		#1;
	endtask

	function automatic logic pairExp(input logic [2:0] c, input logic pin, input logic tm);
		case (c)
			PAIR_PIN:   return pin;
			PAIR_TIMER: return tm;
			PAIR_CMPA:  return src[3];
			PAIR_CMPB:  return src[4];
			default:    return 1'b0;
		endcase
	endfunction

	function automatic logic dacExp(input logic [2:0] c);
		case (c)
			DSYNC_PIT:    return src[5];
			DSYNC_RELOAD: return src[6];
			DSYNC_TA0:    return src[0];
			DSYNC_TA1:    return src[1];
			default:      return 1'b0;
		endcase
	endfunction

	task automatic end_of_test();
		if (n_mismatch == 0 && checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// ********************************************************
	// Test sequence
	// ********************************************************
	initial begin
		logic [31:0] r;
		logic        e;
		logic [1:0]  ex;
		logic [2:0]  codes [5] = '{3'h0, 3'h1, 3'h3, 3'h4, 3'h5};
		logic [11:0] vals [5] = '{12'h600, 12'h900, 12'h800, 12'h100, 12'h400};
		repeat (12) @(posedge sys_clk);
		rstn <= 1'b1;
		foreach (codes[i]) begin
			apb(1'b0, A_MOD + 12'(4 * (i % 3)), 0, r, e);
			chk(r, 0);
		end
		// The far-side model never enables a peripheral, so selections may change at any time.
		for (int p = 0; p < 2; p++) begin
			pins <= p ? 5'h0a : 5'h15;
			repeat (3) @(posedge sys_clk);
			foreach (codes[i]) begin
				wrc(A_MOD, {codes[i], codes[i]}, {codes[i], codes[i]});
				chk(p01s, pairExp(codes[i], pins[0], src[0]));
				chk(p23s, pairExp(codes[i], pins[1], src[2]));
				wrc(A_DAC, {codes[i], 1'b0, codes[i]}, {codes[i], 1'b0, codes[i]});
				chk(d0, dacExp(codes[i]));
				chk(d1, dacExp(codes[i]));
			end
			// The bench runs the modulator and timer on one clock, so the reload sync choice is legal.
			for (int t = 0; t < 2; t++) begin
				wrc(A_TMR, t ? 32'h0000_1110 : 32'h0000_0000, t ? 32'h0000_1110 : 32'h0000_0000);
				chk(t1, t ? src[3] : pins[2]);
				chk(t2, t ? src[4] : pins[3]);
				chk(t3, t ? src[6] : pins[4]);
			end
		end
		wrc(A_DAC, 32'hffff_ffff, {16'h0000, WMASK_DAC_SEL});
		chk(d0, 0);
		wrc(A_TMR, 32'hffff_ffff, {16'h0000, WMASK_TMR_SEL});
		// A write with only the low byte lane enabled leaves the upper byte alone.
		pstrb <= 4'h1;
		wrc(A_TMR, 32'h0000_0000, 32'h0000_1100);
		pstrb <= 4'hf;
		apb(1'b1, 12'h06c, 32'h0000_ffff, r, e);
		chk(e, 1);
		apb(1'b0, 12'h06c, 0, r, e);
		chk({r[30:0], e}, 1);
		wrc(A_MOD, 32'h0000_0012, 32'h0000_0012);
		chk({p01m, p23m}, 2'b11);
		for (int w = 0; w < 2; w++) begin
			ex = 2'b00;
			foreach (vals[i]) begin
				adc(w[0], vals[i]);
				if (vals[i] > hiLim) ex = 2'b01;
				else if (vals[i] < loLim) ex = 2'b10;
				chk(w ? {w2, w3} : {w0, w1}, ex);
			end
		end
		end_of_test();
	end

	initial begin
		#200000;
		n_mismatch++;
		end_of_test();
	end
endmodule // tb_top

bind iss_source_select iss_source_select_sva #(.ADDR_W(ADDR_W), .ADC_W(ADC_W)) u_sva (.*);
